// ===== hw/ssl_pkg.sv
// shared constants and types for the sideband serial link client
package ssl_pkg;
    // system clock and the four selectable line rates
    localparam int CLK_HZ = 100_000_000;
    localparam int BPS_0  = 62_500;
    localparam int BPS_1  = 125_000;
    localparam int BPS_2  = 250_000;   // boot rate
    localparam int BPS_3  = 500_000;
    // clocks per bit, derived from rate and clock
    localparam logic [15:0] DIV_0 = 16'(CLK_HZ / BPS_0);
    localparam logic [15:0] DIV_1 = 16'(CLK_HZ / BPS_1);
    localparam logic [15:0] DIV_2 = 16'(CLK_HZ / BPS_2);
    localparam logic [15:0] DIV_3 = 16'(CLK_HZ / BPS_3);
    // frame: start, 8 data, odd parity, stop
    localparam logic [3:0] FRAME_LAST = 4'hA;
    // command codes (seven bits)
    localparam logic [6:0] CMD_BAUD  = 7'h00;
    localparam logic [6:0] CMD_LINK  = 7'h01;
    localparam logic [6:0] CMD_PROF  = 7'h02;
    localparam logic [6:0] CMD_TXN   = 7'h03;
    localparam logic [6:0] CMD_RXN   = 7'h04;
    localparam logic [6:0] CMD_RATE  = 7'h05;
    localparam logic [6:0] CMD_START = 7'h7E;
    // reply status codes
    localparam logic [7:0] STS_OK    = 8'h00;
    localparam logic [7:0] STS_UNSUP = 8'h01;
    localparam logic [7:0] STS_CSUM  = 8'h02;
    // header of a client data packet: origin bit set
    localparam logic [7:0] HDR_CLIENT = 8'h80;
    // packet lengths in bytes
    localparam logic [2:0] CMD_LEN = 3'h4;
    localparam logic [2:0] PKT1_LEN = 3'h3;
    localparam logic [2:0] PKT2_LEN = 3'h4;
    // link configuration
    typedef struct packed {
        logic       running;   // data exchange started
        logic [1:0] refresh;   // 0 500us, 1 750us, 2 1ms
        logic [1:0] rx_n;      // bytes the host receives
        logic [1:0] tx_n;      // bytes the host sends
        logic       profile;   // 0 simple, 1 addressed
        logic [7:0] dir;       // direction mode
        logic [7:0] conn;      // connection type
        logic [1:0] baud;      // rate select
    } ssl_cfg_t;
    localparam ssl_cfg_t CFG_RST = '{running: 1'b0, refresh: 2'h0, rx_n: 2'h1,
        tx_n: 2'h1, profile: 1'b0, dir: 8'h00, conn: 8'h00, baud: 2'h2};
endpackage : ssl_pkg

// ===== hw/ssl_client.sv
// client end of the one-wire sideband serial link
`timescale 1ns/1ps
module ssl_client
    import ssl_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_reset,
    input  wire logic        i_swire,       // shared line, sensed
    output logic             o_swire,       // shared line, driven value
    output logic             o_swire_oe_n,  // low while driving
    input  wire logic [15:0] i_gpio_in,     // sideband inputs to send
    output logic      [15:0] o_gpio_out,    // sideband outputs received
    output ssl_cfg_t         o_cfg,         // current link settings
    output logic             o_pkt_drop     // pulse: packet discarded
);
    typedef enum logic [2:0] {
        ST_CFG = 3'b001,   // collecting a command
        ST_DAT = 3'b010,   // collecting a data packet
        ST_RPL = 3'b100    // sending the answer
    } ssl_st_t;

    // per-rate divider lookup
    function automatic logic [15:0] baud_div(input logic [1:0] s);
        case (s)
            2'h0:    baud_div = DIV_0;
            2'h1:    baud_div = DIV_1;
            2'h2:    baud_div = DIV_2;
            default: baud_div = DIV_3;
        endcase
    endfunction : baud_div

    // which parameter values each command supports
    function automatic logic [7:0] cmd_sts(input logic [6:0] c, input logic [15:0] p);
        logic ok;
        ok = 1'b0;
        case (c)
            CMD_BAUD:  ok = (p <= 16'h0003);
            CMD_LINK:  ok = (p == 16'h0000);
            CMD_PROF:  ok = (p <= 16'h0001);
            CMD_TXN,
            CMD_RXN:   ok = (p == 16'h0001) || (p == 16'h0002);
            CMD_RATE:  ok = (p <= 16'h0002);
            CMD_START: ok = (p == 16'h0000);
            default:   ok = 1'b0;
        endcase
        cmd_sts = ok ? STS_OK : STS_UNSUP;
    endfunction : cmd_sts

    ssl_cfg_t    cfg_q;           // live settings
    logic [1:0]  baud_pend_q;     // rate taken after the reply
    logic [15:0] div;             // clocks per bit now
    logic        sw_m_q, sw_s_q;  // line synchroniser
    logic [15:0] gp_m_q, gp_s_q;  // input synchroniser

    assign div   = baud_div(cfg_q.baud);
    assign o_cfg = cfg_q;

    // two-flop synchronisers for the pins
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            sw_m_q <= 1'b1;
            sw_s_q <= 1'b1;
            gp_m_q <= 16'h0000;
            gp_s_q <= 16'h0000;
        end else begin
            sw_m_q <= i_swire;
            sw_s_q <= sw_m_q;
            gp_m_q <= i_gpio_in;
            gp_s_q <= gp_m_q;
        end
    end

    // transmitter state
    logic        tx_busy_q;      // frame in flight
    logic [10:0] tx_sh_q;        // stop, parity, data, start
    logic [15:0] tx_cnt_q;       // clocks left in bit
    logic [3:0]  tx_nb_q;        // bit index
    logic        tx_ld_q;        // load request, one cycle
    logic [7:0]  tx_dat_q;       // byte to load

    // transmitter: shift reg idles all ones, so the line rests high
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            tx_busy_q <= 1'b0;
            tx_sh_q   <= '1;
            tx_cnt_q  <= 16'h0000;
            tx_nb_q   <= 4'h0;
        end else if (!tx_busy_q && tx_ld_q) begin
            tx_busy_q <= 1'b1;
            tx_sh_q   <= {1'b1, ~^tx_dat_q, tx_dat_q, 1'b0};
            tx_cnt_q  <= div - 16'h0001;
            tx_nb_q   <= 4'h0;
        end else if (tx_busy_q) begin
            if (tx_cnt_q != 16'h0000) begin
                tx_cnt_q <= tx_cnt_q - 16'h0001;
            end else begin
                tx_cnt_q <= div - 16'h0001;
                tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
                tx_nb_q  <= tx_nb_q + 4'h1;
                if (tx_nb_q == FRAME_LAST) begin
                    tx_busy_q <= 1'b0;
                end
            end
        end
    end

    assign o_swire      = tx_sh_q[0];
    assign o_swire_oe_n = ~tx_busy_q;

    // receiver state
    logic        rx_busy_q;      // sampling a frame
    logic        rx_arm_q;       // line seen high since last frame
    logic [15:0] rx_cnt_q;       // clocks to next sample
    logic [10:0] rx_sh_q;        // sampled bits
    logic [3:0]  rx_nb_q;        // bit index
    logic        rx_vld_q;       // pulse: frame ended
    logic        rx_err_q;       // framing or parity fault
    logic        rx_brk_q;       // all-low frame: restart sequence
    logic [7:0]  rx_byte_q;      // received data
    logic [10:0] frm;            // frame with the last bit

    assign frm = {sw_s_q, rx_sh_q[10:1]};

    // receiver: deaf while driving so our own frames are not heard;
    // arming on a high level keeps a held-low break from retriggering
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            rx_busy_q <= 1'b0;
            rx_arm_q  <= 1'b0;
            rx_cnt_q  <= 16'h0000;
            rx_sh_q   <= 11'h000;
            rx_nb_q   <= 4'h0;
            rx_vld_q  <= 1'b0;
            rx_err_q  <= 1'b0;
            rx_brk_q  <= 1'b0;
            rx_byte_q <= 8'h00;
        end else begin
            rx_vld_q <= 1'b0;
            if (tx_busy_q || tx_ld_q) begin
                rx_busy_q <= 1'b0;
                rx_arm_q  <= 1'b0;
            end else if (!rx_busy_q) begin
                if (sw_s_q) begin
                    rx_arm_q <= 1'b1;
                end else if (rx_arm_q) begin
                    rx_busy_q <= 1'b1;
                    rx_cnt_q  <= {1'b0, div[15:1]};   // sample mid-bit
                    rx_nb_q   <= 4'h0;
                end
            end else if (rx_cnt_q != 16'h0000) begin
                rx_cnt_q <= rx_cnt_q - 16'h0001;
            end else begin
                rx_cnt_q <= div - 16'h0001;
                rx_sh_q  <= frm;
                rx_nb_q  <= rx_nb_q + 4'h1;
                if (rx_nb_q == FRAME_LAST) begin
                    rx_busy_q <= 1'b0;
                    rx_arm_q  <= 1'b0;
                    rx_vld_q  <= 1'b1;
                    rx_byte_q <= frm[8:1];
                    rx_brk_q  <= (frm == 11'h000);
                    rx_err_q  <= frm[0] || !frm[10] || !(^frm[9:1]);
                end
            end
        end
    end

    // packet assembly and answers
    ssl_st_t    st_q;
    logic [7:0] in_q [4];        // bytes collected
    logic [2:0] in_idx_q;
    logic [7:0] out_q [4];       // bytes to send
    logic [2:0] out_len_q;
    logic [2:0] out_idx_q;
    logic [2:0] pkt_len;         // host data packet length
    logic [7:0] csum;            // sum of the first three bytes
    logic [7:0] sts;             // status for a full command
    logic       last;            // this byte completes the packet

    assign pkt_len = (cfg_q.tx_n == 2'h2) ? PKT2_LEN : PKT1_LEN;
    assign csum    = in_q[0] + in_q[1] + in_q[2];
    assign sts     = cmd_sts(in_q[0][6:0], {in_q[1], in_q[2]});
    assign last    = (in_idx_q + 3'h1) == ((st_q == ST_CFG) ? CMD_LEN : pkt_len);

    // protocol engine: every answer follows a host packet or a restart break
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            st_q        <= ST_CFG;
            cfg_q       <= CFG_RST;
            baud_pend_q <= CFG_RST.baud;
            in_idx_q    <= 3'h0;
            out_len_q   <= 3'h0;
            out_idx_q   <= 3'h0;
            tx_ld_q     <= 1'b0;
            tx_dat_q    <= 8'h00;
            o_gpio_out  <= 16'h0000;
            o_pkt_drop  <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                in_q[i]  <= 8'h00;
                out_q[i] <= 8'h00;
            end
        end else begin
            tx_ld_q    <= 1'b0;
            o_pkt_drop <= 1'b0;
            case (st_q)
                ST_CFG, ST_DAT: begin
                    if (rx_vld_q && rx_brk_q) begin
                        // restart: back to configuration, settings kept
                        cfg_q.running <= 1'b0;
                        in_idx_q      <= 3'h0;
                        out_q[0]      <= STS_OK;
                        out_len_q     <= 3'h1;
                        out_idx_q     <= 3'h0;
                        st_q          <= ST_RPL;
                    end else if (rx_vld_q && rx_err_q) begin
                        in_idx_q   <= 3'h0;
                        o_pkt_drop <= 1'b1;
                    end else if (rx_vld_q && in_idx_q == 3'h0 && rx_byte_q[7]) begin
                        // origin flag or command MSB wrong: not from the host
                        o_pkt_drop <= 1'b1;
                    end else if (rx_vld_q && !last) begin
                        in_q[in_idx_q[1:0]] <= rx_byte_q;
                        in_idx_q       <= in_idx_q + 3'h1;
                    end else if (rx_vld_q && st_q == ST_CFG) begin
                        in_idx_q  <= 3'h0;
                        out_q[0]  <= in_q[0];
                        out_len_q <= 3'h2;
                        out_idx_q <= 3'h0;
                        st_q      <= ST_RPL;
                        if (csum != rx_byte_q) begin
                            out_q[1] <= STS_CSUM;
                        end else begin
                            out_q[1] <= sts;
                            if (sts == STS_OK) begin
                                case (in_q[0][6:0])
                                    CMD_BAUD:  baud_pend_q   <= in_q[2][1:0];
                                    CMD_LINK: begin
                                        cfg_q.dir  <= in_q[1];
                                        cfg_q.conn <= in_q[2];
                                    end
                                    CMD_PROF:  cfg_q.profile <= in_q[2][0];
                                    CMD_TXN:   cfg_q.tx_n    <= in_q[2][1:0];
                                    CMD_RXN:   cfg_q.rx_n    <= in_q[2][1:0];
                                    CMD_RATE:  cfg_q.refresh <= in_q[2][1:0];
                                    CMD_START: cfg_q.running <= 1'b1;
                                    default:   cfg_q.running <= cfg_q.running;
                                endcase
                            end
                        end
                    end else if (rx_vld_q) begin
                        // complete host data packet
                        in_idx_q <= 3'h0;
                        if (cfg_q.tx_n == 2'h1 && in_q[1] != rx_byte_q) begin
                            o_pkt_drop <= 1'b1;
                        end else if (cfg_q.tx_n == 2'h2 && csum != rx_byte_q) begin
                            o_pkt_drop <= 1'b1;
                        end else begin
                            if (cfg_q.tx_n == 2'h1) begin
                                o_gpio_out[7:0] <= in_q[1];
                            end else begin
                                o_gpio_out <= {in_q[2], in_q[1]};
                            end
                            // answer sized by the host receive setting
                            out_q[0]  <= HDR_CLIENT;
                            out_q[1]  <= gp_s_q[7:0];
                            out_idx_q <= 3'h0;
                            st_q      <= ST_RPL;
                            if (cfg_q.rx_n == 2'h1) begin
                                out_q[2]  <= gp_s_q[7:0];
                                out_len_q <= PKT1_LEN;
                            end else begin
                                out_q[2]  <= gp_s_q[15:8];
                                out_q[3]  <= HDR_CLIENT + gp_s_q[7:0] + gp_s_q[15:8];
                                out_len_q <= PKT2_LEN;
                            end
                        end
                    end
                end
                ST_RPL: begin
                    // one byte at a time; load only when the line is free;
                    // a host still holding a restart low keeps the answer back
                    if (!tx_busy_q && !tx_ld_q && sw_s_q) begin
                        if (out_idx_q == out_len_q) begin
                            cfg_q.baud <= baud_pend_q;  // new rate after the answer
                            st_q       <= cfg_q.running ? ST_DAT : ST_CFG;
                        end else begin
                            tx_ld_q   <= 1'b1;
                            tx_dat_q  <= out_q[out_idx_q[1:0]];
                            out_idx_q <= out_idx_q + 3'h1;
                        end
                    end
                end
                default: st_q <= ST_CFG;
            endcase
        end
    end
endmodule : ssl_client

// ===== tb/ssl_client_assertions.sv
// port checker for the sideband serial link client
`timescale 1ns/1ps
module ssl_client_assertions
    import ssl_pkg::*;
(
    input wire logic        i_ref_clk,
    input wire logic        i_reset,
    input wire logic        i_swire,
    input wire logic        o_swire,
    input wire logic        o_swire_oe_n,
    input wire logic [15:0] i_gpio_in,
    input wire logic [15:0] o_gpio_out,
    input wire ssl_cfg_t    o_cfg,
    input wire logic        o_pkt_drop
);
    // slowest frame plus margin, so a prompt answer always fits
    localparam logic [15:0] QUIET_MAX = 16'h4524;
    logic [15:0] low_q;    // cycles with the driver on
    logic [15:0] quiet_q;  // cycles since the wire was low or driven
    logic [15:0] bit_len;  // clocks per bit at the current rate
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    // rate select to clocks per bit
    always_comb begin
        case (o_cfg.baud)
            2'h0:    bit_len = DIV_0;
            2'h1:    bit_len = DIV_1;
            2'h2:    bit_len = DIV_2;
            default: bit_len = DIV_3;
        endcase
    end
    // length of the current drive burst
    always_ff @(posedge i_ref_clk) begin
        low_q <= (i_reset || o_swire_oe_n) ? 16'h0000 : low_q + 16'h0001;
    end
    // saturating idle count; starts saturated so reset is not traffic
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            quiet_q <= 16'hFFFF;
        end else if (!i_swire || !o_swire_oe_n) begin
            quiet_q <= 16'h0000;
        end else if (quiet_q != 16'hFFFF) begin
            quiet_q <= quiet_q + 16'h0001;
        end
    end
    a_reset_state: assert property (disable iff (1'b0)
        i_reset |=> o_swire_oe_n && o_swire && o_cfg == CFG_RST && o_gpio_out == 16'h0000)
        else $error("reset state wrong");
    a_idle_high: assert property (o_swire_oe_n |-> o_swire)
        else $error("idle wire not high");
    a_start_bit: assert property ($fell(o_swire_oe_n) |-> !o_swire [*8])
        else $error("start bit missing");
    a_stop_bit: assert property ($rose(o_swire_oe_n) |-> $past(o_swire))
        else $error("stop bit missing");
    a_frame_len: assert property ($rose(o_swire_oe_n) |-> low_q == 16'(11 * bit_len))
        else $error("drive burst not eleven bits");
    a_no_unprompted: assert property ($fell(o_swire_oe_n) |-> quiet_q < QUIET_MAX)
        else $error("client sent unprompted");
    a_drop_pulse: assert property (o_pkt_drop |=> !o_pkt_drop)
        else $error("drop pulse too long");
    a_cfg_steady: assert property (!$stable(o_cfg) |-> o_swire_oe_n)
        else $error("settings changed while answering");
    a_gpio_running: assert property (!$stable(o_gpio_out) |-> o_cfg.running)
        else $error("outputs changed outside data exchange");
    c_answer: cover property ($fell(o_swire_oe_n));
    c_drop: cover property (o_pkt_drop);
    c_start: cover property ($rose(o_cfg.running));
    c_gpio: cover property (!$stable(o_gpio_out));
endmodule : ssl_client_assertions

bind ssl_client ssl_client_assertions ssl_client_assertions_i (
    .i_ref_clk    (i_ref_clk),
    .i_reset      (i_reset),
    .i_swire      (i_swire),
    .o_swire      (o_swire),
    .o_swire_oe_n (o_swire_oe_n),
    .i_gpio_in    (i_gpio_in),
    .o_gpio_out   (o_gpio_out),
    .o_cfg        (o_cfg),
    .o_pkt_drop   (o_pkt_drop)
);

// ===== tb/ssl_host_model.sv
// behavioural host on the shared wire
`timescale 1ns/1ps
module ssl_host_model
    import ssl_pkg::*;
(
    input  wire logic i_ref_clk,
    input  wire logic i_line,  // resolved wire level
    output logic      o_bit,   // value the host drives
    output logic      o_drv    // high while the host drives
);
    logic [15:0] div = DIV_2;  // clocks per bit, boot rate
    // released at boot so the wire idles high
    initial begin
        o_bit = 1'b1;
        o_drv = 1'b0;
    end
    // one 8O1 frame, lsb first; stop held half a bit so the answer never clashes
    task automatic send_byte(input logic [7:0] b, input logic bad_par);
        logic [10:0] fr;
        fr = {1'b1, ~^b ^ bad_par, b, 1'b0};
        repeat (div) @(posedge i_ref_clk);
        #1;
        o_drv = 1'b1;
        for (int i = 0; i < 11; i++) begin
            o_bit = fr[i];
            repeat ((i == 10) ? div / 2 : div) @(posedge i_ref_clk);
            #1;
        end
        o_drv = 1'b0;
    endtask : send_byte
    // restart: wire low for twelve bit times, then released
    task automatic send_break();
        @(posedge i_ref_clk);
        #1;
        o_drv = 1'b1;
        o_bit = 1'b0;
        repeat (12 * div) @(posedge i_ref_clk);
        #1;
        o_drv = 1'b0;
        o_bit = 1'b1;
    endtask : send_break
    // listens only after its own packet, so every exchange is host led
    task automatic recv_byte(output logic [7:0] b, output logic ok);
        logic [10:0] fr;
        int          n;
        n = 0;
        while (i_line !== 1'b0 && n < 4000) begin
            @(posedge i_ref_clk);
            n++;
        end
        repeat (div / 2) @(posedge i_ref_clk);
        for (int i = 0; i < 11; i++) begin
            fr[i] = i_line;
            if (i < 10) begin
                repeat (div) @(posedge i_ref_clk);
            end
        end
        b = fr[8:1];
        ok = (n < 4000) && !fr[0] && fr[10] && (^fr[9:1] === 1'b1);
    endtask : recv_byte
endmodule : ssl_host_model

// ===== tb/ssl_client_bench.sv
// self-checking bench for the sideband serial link client
`timescale 1ns/1ps
module ssl_client_bench
    import ssl_pkg::*;
;
    localparam int LIMIT = 300_000;     // cycle ceiling for the whole run
    logic        i_ref_clk = 1'b0;      // 100 MHz
    logic        i_reset = 1'b1;        // held 8 cycles
    logic [15:0] i_gpio_in = 16'hC35A;  // sideband inputs
    logic        o_swire;
    logic        o_swire_oe_n;
    logic [15:0] o_gpio_out;
    ssl_cfg_t    o_cfg;
    logic        o_pkt_drop;
    logic        h_bit;
    logic        h_drv;
    int          fail_count = 0;
    int          n_tests = 0;
    int          drops = 0;             // drop pulses seen
    int          cyc = 0;
    int          d0;
    // pull-up holds a released wire high; a clash reads low
    wire         line = (o_swire_oe_n ? 1'b1 : o_swire) & (h_drv ? h_bit : 1'b1);
    always #5 i_ref_clk = ~i_ref_clk;
    ssl_client ssl_client_i (
        .i_ref_clk    (i_ref_clk),
        .i_reset      (i_reset),
        .i_swire      (line),
        .o_swire      (o_swire),
        .o_swire_oe_n (o_swire_oe_n),
        .i_gpio_in    (i_gpio_in),
        .o_gpio_out   (o_gpio_out),
        .o_cfg        (o_cfg),
        .o_pkt_drop   (o_pkt_drop)
    );
    ssl_host_model ssl_host_model_i (
        .i_ref_clk (i_ref_clk),
        .i_line    (line),
        .o_bit     (h_bit),
        .o_drv     (h_drv)
    );
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict
    // drop pulses are counted; a hang is cut off
    always @(posedge i_ref_clk) begin
        cyc++;
        if (o_pkt_drop === 1'b1) begin
            drops++;
        end
        if (cyc == LIMIT) begin
            fail_count++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // send ntx bytes, then expect nrx reply bytes, first byte in the top slot
    task automatic xfer(input logic [31:0] tx, input int ntx, input logic [31:0] rx,
                        input int nrx);
        logic [7:0] b;
        logic       ok;
        for (int i = ntx - 1; i >= 0; i--) begin
            ssl_host_model_i.send_byte(tx[8*i+:8], 1'b0);
        end
        for (int i = nrx - 1; i >= 0; i--) begin
            ssl_host_model_i.recv_byte(b, ok);
            chk({23'h0, ok, b}, {24'h01, rx[8*i+:8]});
        end
    endtask : xfer
    // command, parameter, byte sum (bad skews it), then echo and status back
    task automatic cmd(input logic [7:0] c, input logic [15:0] p, input logic [7:0] st,
                       input logic [7:0] bad);
        xfer({c, p, c + p[15:8] + p[7:0] + bad}, 4, {16'h0000, c, st}, 2);
    endtask : cmd
    initial begin
        repeat (8) @(posedge i_ref_clk);
        #1;
        i_reset = 1'b0;
        repeat (4) @(posedge i_ref_clk);
        chk(o_cfg, CFG_RST);
        chk({o_swire_oe_n, o_swire, o_gpio_out}, 32'h0003_0000);
        cmd({1'b0, CMD_BAUD}, 16'h0003, STS_OK, 8'h00);
        ssl_host_model_i.div = DIV_3;
        repeat (400) @(posedge i_ref_clk);
        chk(o_cfg.baud, 2'h3);
        d0 = drops;
        ssl_host_model_i.send_byte(8'h05, 1'b1);
        ssl_host_model_i.send_byte(8'h85, 1'b0);
        repeat (50) @(posedge i_ref_clk);
        chk(drops - d0, 2);
        cmd({1'b0, CMD_RATE}, 16'h0002, STS_OK, 8'h00);
        cmd({1'b0, CMD_LINK}, 16'h0000, STS_OK, 8'h00);
        chk({o_cfg.dir, o_cfg.conn}, 16'h0000);
        cmd({1'b0, CMD_PROF}, 16'h0002, STS_UNSUP, 8'h00);
        cmd({1'b0, CMD_TXN}, 16'h0002, STS_CSUM, 8'h01);
        cmd(8'h10, 16'h0000, STS_UNSUP, 8'h00);
        chk({o_cfg.refresh, o_cfg.profile, o_cfg.tx_n}, 5'h11);
        cmd({1'b0, CMD_START}, 16'h0000, STS_OK, 8'h00);
        chk(o_cfg.running, 1'b1);
        xfer(32'h0000_A5A5, 3, {8'h00, HDR_CLIENT, 16'h5A5A}, 3);
        chk(o_gpio_out, 16'h00A5);
        d0 = drops;
        xfer(32'h0000_3CC3, 3, 32'h0000_0000, 0);
        repeat (100) @(posedge i_ref_clk);
        chk(drops - d0, 1);
        chk(o_gpio_out, 16'h00A5);
        ssl_host_model_i.send_break();
        xfer(32'h0000_0000, 0, 32'h0000_0000, 1);
        chk(o_cfg.running, 1'b0);
        cmd({1'b0, CMD_TXN}, 16'h0002, STS_OK, 8'h00);
        cmd({1'b0, CMD_RXN}, 16'h0002, STS_OK, 8'h00);
        cmd({1'b0, CMD_START}, 16'h0000, STS_OK, 8'h00);
        chk({o_cfg.tx_n, o_cfg.rx_n}, 4'hA);
        xfer(32'h0034_1246, 4, 32'h805A_C39D, 4);
        chk(o_gpio_out, 16'h1234);
        print_verdict();
    end
endmodule : ssl_client_bench
